// ===== hw/btn_chan.sv
// push-button channel telegram response with AXI4-Lite configuration
// Functional notes
// - a double-click telegram uses the object type configured for the short press.
// - a per-object enable turns on cyclic repetition, timed by the channel cycle time.
// - after bus restoration send nothing or an update at once or after 5, 10 or 15 s.
// - the update carries the short, long or double-click value as selected.
// - with the block response set to ignore the block input has no effect.
// - on setting the block send nothing or the short, long or double-click telegram.
// - on cancelling the block send nothing or the short, long or double-click telegram.
// - while blocked no cyclic repetition is sent.
// - block polarity is selectable: 1 blocks by default, 0 blocks when inverted.
//
// The AXI4-Lite interface to the registers and the register addresses are this design's own decisions.
`include "btn_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module btn_chan import btn_pkg::*; #(
  parameter int unsigned SEC_CYCLES = `BTN_SEC_CYCLES
) (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        evt_short,
  input  wire logic        evt_long,
  input  wire logic        evt_dbl,
  input  wire logic        block_rx,
  input  wire logic        block_bit,
  input  wire logic        bus_ok_pin,
  output logic             tx_valid,
  input  wire logic        tx_ready,
  output logic [1:0]       tx_kind,
  output logic [2:0]       tx_type,
  output logic [31:0]      tx_value
);
  // ---------------------------------------------------------------------------
  // register file
  // ---------------------------------------------------------------------------
  logic [31:0]   ctrl_r, vshort_r, vlong_r, vdbl_r;
  logic [15:0]   cycle_r;
  logic          bvalid_r, rvalid_r;
  logic [1:0]    bresp_r, rresp_r;
  logic [31:0]   rdata_r;
  logic          wr_go, rd_go;
  logic [31:0]   status;
  logic          sync1_r, sync2_r, bus_prev_r, rst_edge;
  logic          blk_raw_r, blocked_eff, rst_wait_r, last_valid_r;
  logic [1:0]    last_kind_r;
  btn_tx_state_t tx_st_r;

  assign wr_go         = s_axi_awvalid && s_axi_wvalid && !bvalid_r;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign rd_go         = s_axi_arvalid && !rvalid_r;
  assign s_axi_arready = rd_go;
  assign s_axi_bvalid  = bvalid_r;
  assign s_axi_bresp   = bresp_r;
  assign s_axi_rvalid  = rvalid_r;
  assign s_axi_rresp   = rresp_r;
  assign s_axi_rdata   = rdata_r;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl_r   <= `BTN_CTRL_RST;
      vshort_r <= '0;
      vlong_r  <= '0;
      vdbl_r   <= '0;
      cycle_r  <= `BTN_CYCLE_RST;
      bvalid_r <= 1'b0;
      bresp_r  <= `BTN_RESP_OKAY;
    end else begin
      if (wr_go) begin
        bvalid_r <= 1'b1;
        bresp_r  <= `BTN_RESP_OKAY;
        case (s_axi_awaddr)
          `BTN_A_CTRL:   ctrl_r   <= merge(ctrl_r, s_axi_wdata, s_axi_wstrb);
          `BTN_A_VSHORT: vshort_r <= merge(vshort_r, s_axi_wdata, s_axi_wstrb);
          `BTN_A_VLONG:  vlong_r  <= merge(vlong_r, s_axi_wdata, s_axi_wstrb);
          `BTN_A_VDBL:   vdbl_r   <= merge(vdbl_r, s_axi_wdata, s_axi_wstrb);
          `BTN_A_CYCLE:  cycle_r  <= 16'(merge({16'h0000, cycle_r}, s_axi_wdata, s_axi_wstrb));
          `BTN_A_STATUS: ;
          default:       bresp_r  <= `BTN_RESP_SLV;
        endcase
      end else if (s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  assign status = {25'h0, last_valid_r, last_kind_r, tx_st_r == TX_BUSY, rst_wait_r,
                   sync2_r, blocked_eff};

  always_ff @(posedge mclk) begin
    if (srst) begin
      rvalid_r <= 1'b0;
      rresp_r  <= `BTN_RESP_OKAY;
      rdata_r  <= '0;
    end else if (rd_go) begin
      rvalid_r <= 1'b1;
      rresp_r  <= `BTN_RESP_OKAY;
      case (s_axi_araddr)
        `BTN_A_CTRL:   rdata_r <= ctrl_r;
        `BTN_A_VSHORT: rdata_r <= vshort_r;
        `BTN_A_VLONG:  rdata_r <= vlong_r;
        `BTN_A_VDBL:   rdata_r <= vdbl_r;
        `BTN_A_CYCLE:  rdata_r <= {16'h0000, cycle_r};
        `BTN_A_STATUS: rdata_r <= status;
        default: begin
          rdata_r <= '0;
          rresp_r <= `BTN_RESP_SLV;
        end
      endcase
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------------------
  // block object
  // ---------------------------------------------------------------------------
  logic       blk_ignore, blk_set_ev, blk_clr_ev, blk_new;
  logic [2:0] blk_set_sel;
  logic [1:0] blk_clr_sel;

  assign blk_set_sel = ctrl_r[`BTN_F_BLK_SET];
  assign blk_clr_sel = ctrl_r[`BTN_F_BLK_CLR];
  assign blk_ignore  = (blk_set_sel == `BTN_BLK_IGNORE);
  assign blk_new     = block_bit ^ ctrl_r[`BTN_F_BLK_INV];
  assign blocked_eff = blk_raw_r && !blk_ignore;
  assign blk_set_ev  = block_rx && !blk_ignore && blk_new && !blk_raw_r;
  assign blk_clr_ev  = block_rx && !blk_ignore && !blk_new && blk_raw_r;

  always_ff @(posedge mclk) begin
    if (srst) begin
      blk_raw_r <= 1'b0;
    end else if (block_rx && !blk_ignore) begin
      blk_raw_r <= blk_new;
    end
  end

  // ---------------------------------------------------------------------------
  // bus restoration
  // ---------------------------------------------------------------------------
  logic       rst_tick, cyc_tick, launch;
  logic [3:0] rst_cnt_r;
  logic [1:0] rst_src, rst_dly;

  assign rst_src  = ctrl_r[`BTN_F_RST_SRC];
  assign rst_dly  = ctrl_r[`BTN_F_RST_DLY];
  assign rst_edge = sync2_r && !bus_prev_r;

  always_ff @(posedge mclk) begin
    if (srst) begin
      sync1_r    <= 1'b0;
      sync2_r    <= 1'b0;
      bus_prev_r <= 1'b0;
    end else begin
      sync1_r    <= bus_ok_pin;
      sync2_r    <= sync1_r;
      bus_prev_r <= sync2_r;
    end
  end

  // delay restarts at the restore edge; a bus drop abandons a waiting update
  always_ff @(posedge mclk) begin
    if (srst || !sync2_r) begin
      rst_wait_r <= 1'b0;
      rst_cnt_r  <= '0;
    end else if (rst_edge && rst_src != `BTN_SEL_NONE && rst_dly != `BTN_DLY_IMM) begin
      rst_wait_r <= 1'b1;
      unique case (rst_dly)
        2'h1:    rst_cnt_r <= `BTN_DLY1_S;
        2'h2:    rst_cnt_r <= `BTN_DLY2_S;
        default: rst_cnt_r <= `BTN_DLY3_S;
      endcase
    end else if (rst_wait_r && rst_tick) begin
      rst_cnt_r <= rst_cnt_r - 4'h1;
      if (rst_cnt_r == 4'h1) begin
        rst_wait_r <= 1'b0;
      end
    end
  end

  btn_tick #(.CYCLES(SEC_CYCLES)) u_rst_tick (
    .mclk  (mclk),
    .srst  (srst),
    .clear (rst_edge),
    .tick  (rst_tick)
  );

  btn_tick #(.CYCLES(SEC_CYCLES)) u_cyc_tick (
    .mclk  (mclk),
    .srst  (srst),
    .clear (launch),
    .tick  (cyc_tick)
  );

  // ---------------------------------------------------------------------------
  // request sources, each pending until launched (a repeat is also dropped while blocked); a new set wins over the clear
  // ---------------------------------------------------------------------------
  logic       set_blk, set_rst, set_btn, set_cyc;
  logic [1:0] kin_blk, kin_rst, kin_btn;
  logic       pend_blk_r, pend_rst_r, pend_btn_r, pend_cyc_r;
  logic [1:0] kind_blk_r, kind_rst_r, kind_btn_r;
  logic [15:0] cyc_cnt_r;
  btn_src_t   sel;

  always_comb begin
    set_blk = 1'b0;
    kin_blk = `BTN_KIND_SHORT;
    if (blk_set_ev && blk_set_sel != `BTN_BLK_NONE) begin
      set_blk = 1'b1;
      kin_blk = blk_set_sel[1:0] - 2'h2;
    end else if (blk_clr_ev && blk_clr_sel != `BTN_SEL_NONE) begin
      set_blk = 1'b1;
      kin_blk = blk_clr_sel - 2'h1;
    end
  end

  assign set_rst = (rst_edge && rst_src != `BTN_SEL_NONE && rst_dly == `BTN_DLY_IMM) ||
                   (rst_wait_r && rst_tick && rst_cnt_r == 4'h1);
  assign kin_rst = rst_src - 2'h1;

  always_comb begin
    set_btn = 1'b0;
    kin_btn = `BTN_KIND_SHORT;
    if (!blocked_eff) begin
      if (evt_dbl && ctrl_r[`BTN_F_EN_DBL]) begin
        set_btn = 1'b1;
        kin_btn = `BTN_KIND_DBL;
      end else if (evt_long && ctrl_r[`BTN_F_EN_LONG]) begin
        set_btn = 1'b1;
        kin_btn = `BTN_KIND_LONG;
      end else if (evt_short && ctrl_r[`BTN_F_EN_SHORT]) begin
        set_btn = 1'b1;
      end
    end
  end

  // the cycle restarts on every telegram, so repeats follow the last one sent
  assign set_cyc = ctrl_r[`BTN_F_CYC_EN] && !blocked_eff && last_valid_r && cyc_tick &&
                   cycle_r != 16'h0000 && cyc_cnt_r + 16'h1 >= cycle_r;

  always_ff @(posedge mclk) begin
    if (srst || launch || set_cyc) begin
      cyc_cnt_r <= '0;
    end else if (cyc_tick) begin
      cyc_cnt_r <= cyc_cnt_r + 16'h1;
    end
  end

  always_comb begin
    sel = SRC_CYC;
    if (pend_blk_r) begin
      sel = SRC_BLK;
    end else if (pend_rst_r) begin
      sel = SRC_RST;
    end else if (pend_btn_r) begin
      sel = SRC_BTN;
    end
  end

  // a repeat pended in the very cycle the block lands must not slip out under it
  assign launch = (tx_st_r == TX_IDLE) &&
                  (pend_blk_r || pend_rst_r || pend_btn_r || (pend_cyc_r && !blocked_eff));

  always_ff @(posedge mclk) begin
    if (srst) begin
      pend_blk_r <= 1'b0;
      pend_rst_r <= 1'b0;
      pend_btn_r <= 1'b0;
      pend_cyc_r <= 1'b0;
      kind_blk_r <= `BTN_KIND_SHORT;
      kind_rst_r <= `BTN_KIND_SHORT;
      kind_btn_r <= `BTN_KIND_SHORT;
    end else begin
      if (set_blk) begin
        pend_blk_r <= 1'b1;
        kind_blk_r <= kin_blk;
      end else if (launch && sel == SRC_BLK) begin
        pend_blk_r <= 1'b0;
      end
      if (set_rst) begin
        pend_rst_r <= 1'b1;
        kind_rst_r <= kin_rst;
      end else if (launch && sel == SRC_RST) begin
        pend_rst_r <= 1'b0;
      end
      if (set_btn) begin
        pend_btn_r <= 1'b1;
        kind_btn_r <= kin_btn;
      end else if (launch && sel == SRC_BTN) begin
        pend_btn_r <= 1'b0;
      end
      if (set_cyc) begin
        pend_cyc_r <= 1'b1;
      end else if (blocked_eff || (launch && sel == SRC_CYC)) begin
        pend_cyc_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // transmitter handshake
  // ---------------------------------------------------------------------------
  logic [1:0] kind_nxt;

  always_comb begin
    unique case (sel)
      SRC_BLK: kind_nxt = kind_blk_r;
      SRC_RST: kind_nxt = kind_rst_r;
      SRC_BTN: kind_nxt = kind_btn_r;
      SRC_CYC: kind_nxt = last_kind_r;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_st_r      <= TX_IDLE;
      tx_kind      <= `BTN_KIND_SHORT;
      tx_type      <= '0;
      tx_value     <= '0;
      last_kind_r  <= `BTN_KIND_SHORT;
      last_valid_r <= 1'b0;
    end else begin
      unique case (tx_st_r)
        TX_IDLE: begin
          if (launch) begin
            tx_st_r      <= TX_BUSY;
            tx_kind      <= kind_nxt;
            tx_type      <= ctrl_r[`BTN_F_TYPE];
            tx_value     <= (kind_nxt == `BTN_KIND_DBL)  ? vdbl_r :
                            (kind_nxt == `BTN_KIND_LONG) ? vlong_r : vshort_r;
            last_kind_r  <= kind_nxt;
            last_valid_r <= 1'b1;
          end
        end
        TX_BUSY: begin
          if (tx_ready) begin
            tx_st_r <= TX_IDLE;
          end
        end
      endcase
    end
  end

  assign tx_valid = (tx_st_r == TX_BUSY);

  // ---------------------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------------------
  a_dbl_type: assert property (@(posedge mclk) disable iff (srst)
    launch && kind_nxt == `BTN_KIND_DBL |=> tx_kind == `BTN_KIND_DBL &&
      tx_type == $past(ctrl_r[`BTN_F_TYPE])) else $error("double-click type wrong");
  a_cyc_cause: assert property (@(posedge mclk) disable iff (srst)
    $rose(pend_cyc_r) |-> $past(ctrl_r[`BTN_F_CYC_EN]) && $past(cycle_r) != 16'h0000)
    else $error("cyclic repeat without enable");
  a_rst_imm: assert property (@(posedge mclk) disable iff (srst)
    rst_edge && rst_src != `BTN_SEL_NONE && rst_dly == `BTN_DLY_IMM |=> pend_rst_r)
    else $error("immediate update missing");
  a_rst_kind: assert property (@(posedge mclk) disable iff (srst)
    launch && sel == SRC_RST |=> tx_kind == $past(kind_rst_r) && tx_valid)
    else $error("update value wrong");
  a_ignore_blk: assert property (@(posedge mclk) disable iff (srst)
    blk_ignore |-> !blocked_eff && !set_blk) else $error("ignored block acted");
  a_ignore_press: assert property (@(posedge mclk) disable iff (srst)
    blk_ignore && evt_short && ctrl_r[`BTN_F_EN_SHORT] |=> pend_btn_r)
    else $error("press lost under ignored block");
  a_blk_set: assert property (@(posedge mclk) disable iff (srst)
    blk_set_ev && blk_set_sel > `BTN_BLK_NONE |=> pend_blk_r &&
      kind_blk_r == $past(blk_set_sel[1:0]) - 2'h2) else $error("block set response");
  a_blk_clr: assert property (@(posedge mclk) disable iff (srst)
    blk_clr_ev && blk_clr_sel != `BTN_SEL_NONE |=> pend_blk_r &&
      kind_blk_r == $past(blk_clr_sel) - 2'h1) else $error("block cancel response");
  a_no_cyc_blk: assert property (@(posedge mclk) disable iff (srst)
    blocked_eff |=> !pend_cyc_r) else $error("cyclic repeat while blocked");
  a_blk_pol: assert property (@(posedge mclk) disable iff (srst)
    block_rx && !blk_ignore |=> blk_raw_r == ($past(block_bit) ^ $past(ctrl_r[`BTN_F_BLK_INV])))
    else $error("block polarity wrong");
  a_rst_once: assert property (@(posedge mclk) disable iff (srst)
    rst_wait_r && !rst_edge && sync2_r && rst_tick && rst_cnt_r == 4'h1 |=>
      !rst_wait_r && pend_rst_r) else $error("delayed update missing");
endmodule
`default_nettype wire

// ===== hw/btn_regs.svh
// register offsets, fields and timing constants of the button channel
`ifndef BTN_REGS_SVH
`define BTN_REGS_SVH
// -----------------------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------------------
`define BTN_A_CTRL     8'h00
`define BTN_A_VSHORT   8'h04
`define BTN_A_VLONG    8'h08
`define BTN_A_VDBL     8'h0C
`define BTN_A_CYCLE    8'h10
`define BTN_A_STATUS   8'h14
// -----------------------------------------------------------------------------
// control fields
// -----------------------------------------------------------------------------
`define BTN_F_TYPE     2:0
`define BTN_F_EN_SHORT 3
`define BTN_F_EN_LONG  4
`define BTN_F_EN_DBL   5
`define BTN_F_CYC_EN   6
`define BTN_F_BLK_INV  7
`define BTN_F_BLK_SET  10:8
`define BTN_F_BLK_CLR  12:11
`define BTN_F_RST_SRC  14:13
`define BTN_F_RST_DLY  16:15
`define BTN_CTRL_RST   32'h0000_0000
`define BTN_CYCLE_RST  16'h0000
// -----------------------------------------------------------------------------
// field codes
// -----------------------------------------------------------------------------
`define BTN_BLK_IGNORE 3'h0
`define BTN_BLK_NONE   3'h1
`define BTN_KIND_SHORT 2'h0
`define BTN_KIND_LONG  2'h1
`define BTN_KIND_DBL   2'h2
`define BTN_SEL_NONE   2'h0
`define BTN_DLY_IMM    2'h0
// -----------------------------------------------------------------------------
// timing
// -----------------------------------------------------------------------------
`define BTN_CLK_MHZ    100
`define BTN_SEC_MS     1000
`define BTN_SEC_CYCLES (`BTN_SEC_MS * 1000 * `BTN_CLK_MHZ)
`define BTN_DLY1_S     4'h5
`define BTN_DLY2_S     4'hA
`define BTN_DLY3_S     4'hF
`define BTN_RESP_OKAY  2'h0
`define BTN_RESP_SLV   2'h2
`endif

// ===== hw/btn_pkg.sv
// types shared by the button channel design
package btn_pkg;
  typedef enum logic {TX_IDLE, TX_BUSY} btn_tx_state_t;
  typedef enum logic [1:0] {SRC_BLK, SRC_RST, SRC_BTN, SRC_CYC} btn_src_t;
endpackage

// ===== hw/btn_tick.sv
// one-second tick generator, restartable
`timescale 1ns/1ps
`default_nettype none
module btn_tick #(
  parameter int unsigned CYCLES = 100
) (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic clear,
  output logic      tick
);
  localparam int unsigned W = (CYCLES > 1) ? $clog2(CYCLES) : 1;
  logic [W-1:0] cnt_r;

  // clear restarts the period so that a delay counts whole seconds from it
  always_ff @(posedge mclk) begin
    if (srst || clear) begin
      cnt_r <= '0;
    end else if (cnt_r == W'(CYCLES - 1)) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + W'(1);
    end
  end

  assign tick = (cnt_r == W'(CYCLES - 1)) && !clear;
endmodule
`default_nettype wire

// ===== verification/btn_tx_model.sv
// transmitter model at the far side of the button channel
`timescale 1ns/1ps
`default_nettype none
module btn_tx_model (
  input  wire logic        mclk,
  input  wire logic        srst,
  input  wire logic        slow,
  input  wire logic        tx_valid,
  output logic             tx_ready,
  input  wire logic [1:0]  tx_kind,
  input  wire logic [2:0]  tx_type,
  input  wire logic [31:0] tx_value,
  output logic             got,
  output logic [36:0]      got_word
);
  // a slow bus is busy on most cycles, so the channel has to hold its telegram
  always_ff @(posedge mclk) begin
    if (srst) begin
      tx_ready <= 1'b0;
      got      <= 1'b0;
      got_word <= '0;
    end else begin
      tx_ready <= slow ? ($urandom % 4 == 0) : 1'b1;
      got      <= tx_valid && tx_ready;
      got_word <= {tx_kind, tx_type, tx_value};
    end
  end
endmodule
`default_nettype wire

// ===== verification/btn_chan_tb.sv
// self-checking bench of the button channel against a reference queue
`include "btn_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module btn_chan_tb;
  localparam int SEC = 20;
  logic        mclk, srst, slow, cyc_mode, b;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, tx_value;
  logic [3:0]  wstrb;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [1:0]  bresp, rresp, tx_kind;
  logic [2:0]  ev, tx_type, typ;
  logic        block_rx, block_bit, bus_ok, tx_valid, tx_ready, got;
  logic [36:0] got_word, last_w;
  logic [36:0] exp_q[$];
  logic [31:0] vals[3];
  int          failures, num_checks, rx_cnt, cyc_n, t0, c0;

  btn_chan #(.SEC_CYCLES(SEC)) btn_chan_i (
    .mclk, .srst, .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .evt_short(ev[0]), .evt_long(ev[1]), .evt_dbl(ev[2]), .block_rx, .block_bit,
    .bus_ok_pin(bus_ok), .tx_valid, .tx_ready, .tx_kind, .tx_type, .tx_value);
  btn_tx_model btn_tx_model_i (.mclk, .srst, .slow, .tx_valid, .tx_ready, .tx_kind,
    .tx_type, .tx_value, .got, .got_word);

  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) cyc_n++;
  // ----------------------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------------------
  task automatic give_verdict();
    if (failures == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [63:0] e, input logic [63:0] s);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", n, e, s);
    end
  endtask
  task automatic tmo(input int n);
    if (n >= 3000) begin
      failures++;
      give_verdict();
    end
  endtask
  // every accepted telegram is judged against the reference queue, or in cyc_mode against last_w
  always @(posedge mclk) begin
    if (got) begin
      rx_cnt++;
      if (cyc_mode) chk("repeat", last_w, got_word);
      else if (exp_q.size() == 0) chk("extra telegram", 0, 1);
      else chk("telegram", exp_q.pop_front(), got_word);
    end
  end
  function automatic logic [36:0] ew(int k);
    return {k[1:0], typ, vals[k]};
  endfunction
  function automatic logic [31:0] ctl(int en, cy, inv, bs, bc, rs, rdl);
    return {15'h0000, rdl[1:0], rs[1:0], bc[1:0], bs[2:0], inv[0], cy[0], en[2:0], typ};
  endfunction
  // ----------------------------------------------------------------------------
  // bus and event drivers
  // ----------------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (!awready && n < 3000);
    awvalid <= 1'b0;
    wvalid <= 1'b0;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (!bvalid && n < 3000);
    bready <= 1'b0;
    tmo(n);
    chk("bresp", er, bresp);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, m, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (!arready && n < 3000);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (!rvalid && n < 3000);
    rready <= 1'b0;
    tmo(n);
    chk("rdata", e, rdata & m);
    chk("rresp", er, rresp);
  endtask
  task automatic press(input int k);
    @(posedge mclk);
    ev <= 3'h1 << k;
    @(posedge mclk);
    ev <= 3'h0;
  endtask
  task automatic blk(input logic v);
    @(posedge mclk);
    block_rx <= 1'b1;
    block_bit <= v;
    @(posedge mclk);
    block_rx <= 1'b0;
  endtask
  task automatic drain();
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    tmo(n);
    repeat (30) @(posedge mclk);
  endtask
  task automatic wait_rx();
    int n;
    n = 0;
    c0 = rx_cnt;
    while (rx_cnt == c0 && n < 3000) begin
      @(posedge mclk);
      n++;
    end
    tmo(n);
  endtask
  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    {srst, slow, awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
    {ev, block_rx, block_bit, bus_ok, cyc_mode, typ} = '0;
    wstrb = 4'hF;
    srst = 1'b1;
    void'($urandom(93452));
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    rd(`BTN_A_CTRL, 32'h0000_0000, 32'hFFFF_FFFF, `BTN_RESP_OKAY);
    rd(`BTN_A_CYCLE, 32'h0000_0000, 32'hFFFF_FFFF, `BTN_RESP_OKAY);
    rd(`BTN_A_STATUS, 32'h0000_0000, 32'hFFFF_FFFF, `BTN_RESP_OKAY);
    rd(8'h18, 32'h0000_0000, 32'hFFFF_FFFF, `BTN_RESP_SLV);
    wr(8'h18, 32'hFFFF_FFFF, `BTN_RESP_SLV);
    for (int k = 0; k < 3; k++) begin
      vals[k] = $urandom;
      wr(`BTN_A_VSHORT + 8'(4 * k), vals[k], `BTN_RESP_OKAY);
    end
    rd(`BTN_A_VDBL, vals[2], 32'hFFFF_FFFF, `BTN_RESP_OKAY);
    // every kind on a stalling transmitter, then a disabled double-click
    slow <= 1'b1;
    typ = 3'($urandom);
    wr(`BTN_A_CTRL, ctl(7, 0, 0, 1, 0, 0, 0), `BTN_RESP_OKAY);
    for (int k = 0; k < 3; k++) begin
      exp_q.push_back(ew(k));
      press(k);
      drain();
    end
    wr(`BTN_A_CTRL, ctl(3, 0, 0, 1, 0, 0, 0), `BTN_RESP_OKAY);
    press(2);
    drain();
    // block set and cancel responses in both polarities
    for (int inv = 0; inv < 2; inv++) begin
      b = (inv == 0);
      wr(`BTN_A_CTRL, ctl(7, 0, inv, 1, 0, 0, 0), `BTN_RESP_OKAY);
      blk(!b);
      drain();
      for (int r = 0; r < 3; r++) begin
        wr(`BTN_A_CTRL, ctl(7, 0, inv, 2 + r, 1 + r, 0, 0), `BTN_RESP_OKAY);
        exp_q.push_back(ew(r));
        blk(b);
        drain();
        rd(`BTN_A_STATUS, 32'h0000_0001, 32'h0000_0001, `BTN_RESP_OKAY);
        press(0);
        drain();
        exp_q.push_back(ew(r));
        blk(!b);
        drain();
        rd(`BTN_A_STATUS, 32'h0000_0000, 32'h0000_0001, `BTN_RESP_OKAY);
      end
    end
    // an ignored block lets presses through
    wr(`BTN_A_CTRL, ctl(7, 0, 0, 0, 0, 0, 0), `BTN_RESP_OKAY);
    blk(1'b1);
    exp_q.push_back(ew(0));
    press(0);
    drain();
    blk(1'b0);
    drain();
    // cyclic repeats every CYCLE seconds, none while blocked
    slow <= 1'b0;
    wr(`BTN_A_CYCLE, 32'h0000_0002, `BTN_RESP_OKAY);
    wr(`BTN_A_CTRL, ctl(7, 1, 0, 1, 0, 0, 0), `BTN_RESP_OKAY);
    last_w = ew(1);
    cyc_mode = 1'b1;
    press(1);
    wait_rx();
    c0 = rx_cnt;
    // a 2 s cycle fits six repeats in this window, with or without the launch flop
    repeat (6 * 2 * SEC + 10) @(posedge mclk);
    chk("repeat count", 6, rx_cnt - c0);
    blk(1'b1);
    repeat (5) @(posedge mclk);
    c0 = rx_cnt;
    repeat (150) @(posedge mclk);
    chk("blocked repeats", 0, rx_cnt - c0);
    wr(`BTN_A_CTRL, ctl(7, 0, 0, 1, 0, 0, 0), `BTN_RESP_OKAY);
    blk(1'b0);
    wr(`BTN_A_CYCLE, 32'h0000_0000, `BTN_RESP_OKAY);
    repeat (60) @(posedge mclk);
    cyc_mode = 1'b0;
    // bus restoration for every source and delay, enables all off
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 4; d++) begin
        wr(`BTN_A_CTRL, ctl(0, 0, 0, 1, 0, s, d), `BTN_RESP_OKAY);
        if (s != 0) exp_q.push_back(ew(s - 1));
        @(posedge mclk);
        bus_ok <= 1'b1;
        t0 = cyc_n;
        if (s != 0) begin
          wait_rx();
          chk("restore delay", 1, (cyc_n - t0 >= 5 * SEC * d) &&
              (cyc_n - t0 <= 5 * SEC * d + 12));
        end
        c0 = rx_cnt;
        repeat (5 * SEC * 3 + 40) @(posedge mclk);
        chk("restore count", 0, rx_cnt - c0);
        bus_ok <= 1'b0;
        repeat (8) @(posedge mclk);
      end
    end
    give_verdict();
  end
endmodule
`default_nettype wire
